// file: pkg/asrp_pkg.sv
// constants and types for the static memory host port
package asrp_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_PS = 25000;
  // slower grade figures, safe for both grades
  localparam int T_ACC_SEL_NS = 70;
  localparam int T_ACC_OE_NS = 35;
  localparam int T_DIS_NS = 25;
  localparam int T_SU_A_WH_NS = 55;
  localparam int T_WP_NS = 50;
  localparam int T_CYC_NS = 70;
  localparam int T_REC_PD_MS = 5;
  // least times round up
  localparam int C_ACC_SEL = (T_ACC_SEL_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
  localparam int C_ACC_OE = (T_ACC_OE_NS * 1000 + CLK_PERIOD_PS - 1)
                            / CLK_PERIOD_PS;
  localparam int C_DIS = (T_DIS_NS * 1000 + CLK_PERIOD_PS - 1)
                         / CLK_PERIOD_PS;
  localparam int C_SU_A_WH = (T_SU_A_WH_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
  localparam int C_WP = (T_WP_NS * 1000 + CLK_PERIOD_PS - 1)
                        / CLK_PERIOD_PS;
  localparam int C_CYC = (T_CYC_NS * 1000 + CLK_PERIOD_PS - 1)
                         / CLK_PERIOD_PS;
  // five milliseconds in ps overflow a 32-bit int, so work in 64 bits
  localparam longint PS_PER_MS = 64'h0000_0000_3b9a_ca00;
  localparam int C_REC_PD = int'(
    (T_REC_PD_MS * PS_PER_MS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int CNT_W = 18;
  typedef enum logic [2:0] {
    ASRP_RECOVER, ASRP_IDLE, ASRP_RD_WAIT, ASRP_WR_PULSE,
    ASRP_WR_END, ASRP_GAP
  } asrp_state_e;
  typedef struct packed {
    asrp_state_e           state;
    logic [CNT_W-1:0]      cnt;
    logic [ADDR_W-1:0]     word_address;
    logic [DATA_W-1:0]     wdata;
    logic [DATA_W-1:0]     rdata;
    logic                  rvalid;
    logic                  select_low_active_n;
    logic                  select_high_active;
    logic                  write_n;
    logic                  oe_n;
    logic                  data_oe;
  } asrp_regs_s;
endpackage

// file: rtl/asrp_host.sv
// host controller driving an asynchronous 128k x 8 static memory
`timescale 1ns/1ps
module asrp_host #(
  parameter int REC_CYCLES = asrp_pkg::C_REC_PD
) (
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic                        req_valid,
  output logic                             req_ready,
  input  wire logic                        req_write,
  input  wire logic [asrp_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [asrp_pkg::DATA_W-1:0] req_wdata,
  input  wire logic                        standby_req,
  output logic [asrp_pkg::DATA_W-1:0]      rsp_rdata,
  output logic                             rsp_valid,
  output logic [asrp_pkg::ADDR_W-1:0]      word_address,
  output logic                             select_low_active_n,
  output logic                             select_high_active,
  output logic                             write_n,
  output logic                             oe_n,
  input  wire logic [asrp_pkg::DATA_W-1:0] data_lines_in,
  output logic [asrp_pkg::DATA_W-1:0]      data_lines_out,
  output logic                             data_lines_oe
);

  asrp_pkg::asrp_regs_s r;
  asrp_pkg::asrp_regs_s next_r;

  // counter load for a wait of n cycles; zero marks the last cycle
  function automatic logic [asrp_pkg::CNT_W-1:0] cyc(input int n);
    cyc = asrp_pkg::CNT_W'(n - 1);
  endfunction

  // longer of two minimum waits, so one count meets both
  function automatic int longest(input int a, input int b);
    if (a > b) begin
      longest = a;
    end else begin
      longest = b;
    end
  endfunction

  // memory pins at rest: selects off, strobes high, bus let go
  function automatic asrp_pkg::asrp_regs_s parked(
    input asrp_pkg::asrp_regs_s s
  );
    parked                     = s;
    parked.select_low_active_n = 1'b1;
    parked.select_high_active  = 1'b0;
    parked.write_n             = 1'b1;
    parked.oe_n                = 1'b1;
    parked.data_oe             = 1'b0;
  endfunction

  // open a write: strobe falls with the selects, outputs stay off
  function automatic asrp_pkg::asrp_regs_s start_write(
    input asrp_pkg::asrp_regs_s        s,
    input logic [asrp_pkg::ADDR_W-1:0] addr,
    input logic [asrp_pkg::DATA_W-1:0] data
  );
    start_write                     = parked(s);
    start_write.word_address        = addr;
    start_write.wdata               = data;
    start_write.select_low_active_n = 1'b0;
    start_write.select_high_active  = 1'b1;
    start_write.write_n             = 1'b0;
    start_write.data_oe             = 1'b1;
    // strobe low long enough for address setup and pulse width
    start_write.cnt   = cyc(longest(asrp_pkg::C_SU_A_WH,
                                    asrp_pkg::C_WP));
    start_write.state = asrp_pkg::ASRP_WR_PULSE;
  endfunction

  // open a read: selects and output enable fall together
  function automatic asrp_pkg::asrp_regs_s start_read(
    input asrp_pkg::asrp_regs_s        s,
    input logic [asrp_pkg::ADDR_W-1:0] addr
  );
    start_read                     = parked(s);
    start_read.word_address        = addr;
    start_read.select_low_active_n = 1'b0;
    start_read.select_high_active  = 1'b1;
    start_read.oe_n                = 1'b0;
    // one count covers both select and enable access times
    start_read.cnt   = cyc(longest(asrp_pkg::C_ACC_SEL,
                                   asrp_pkg::C_ACC_OE));
    start_read.state = asrp_pkg::ASRP_RD_WAIT;
  endfunction

  // close a read: word latched as enable and selects drop
  function automatic asrp_pkg::asrp_regs_s finish_read(
    input asrp_pkg::asrp_regs_s        s,
    input logic [asrp_pkg::DATA_W-1:0] data
  );
    finish_read        = parked(s);
    finish_read.rdata  = data;
    finish_read.rvalid = 1'b1;
    // turnaround so the memory lets go before anyone drives
    finish_read.cnt    = cyc(asrp_pkg::C_DIS);
    finish_read.state  = asrp_pkg::ASRP_GAP;
  endfunction

  // close a write: selects and our drivers off a cycle after strobe
  function automatic asrp_pkg::asrp_regs_s finish_write(
    input asrp_pkg::asrp_regs_s s
  );
    finish_write       = parked(s);
    finish_write.cnt   = cyc(asrp_pkg::C_DIS);
    finish_write.state = asrp_pkg::ASRP_GAP;
  endfunction

  // request accepted on this edge; running wait on its last cycle
  logic take;
  logic take_write;
  logic take_read;
  logic wait_done;
  assign take      = req_valid && req_ready;
  assign wait_done = (r.cnt == '0);

  // split by direction so each arm of the sequencer reads plainly
  assign take_write = take && req_write;
  assign take_read  = take && !req_write;

  // ready only in idle and not asked to stand by
  assign req_ready = (r.state == asrp_pkg::ASRP_IDLE) && !standby_req;

  // pins straight from flip-flops
  assign word_address        = r.word_address;
  assign select_low_active_n = r.select_low_active_n;
  assign select_high_active  = r.select_high_active;
  assign write_n             = r.write_n;
  assign oe_n                = r.oe_n;
  assign data_lines_out      = r.wdata;
  assign data_lines_oe       = r.data_oe;
  assign rsp_rdata           = r.rdata;
  assign rsp_valid           = r.rvalid;

  // sequencing of read and write cycles
  always_comb begin
    next_r        = r;
    next_r.rvalid = 1'b0;
    if (!wait_done) begin
      next_r.cnt = r.cnt - 1'b1;
    end
    case (r.state)
      // recovery: nothing selected until the wait runs out
      asrp_pkg::ASRP_RECOVER: begin
        next_r = parked(next_r);
        // supply counts as back only once standby is let go
        if (standby_req) begin
          next_r.cnt = cyc(REC_CYCLES);
        end else if (wait_done) begin
          next_r.state = asrp_pkg::ASRP_IDLE;
        end
      end

      // deselected here, so a supply drop finds it idle
      asrp_pkg::ASRP_IDLE: begin
        next_r = parked(next_r);
        if (standby_req) begin
          next_r.cnt   = cyc(REC_CYCLES);
          next_r.state = asrp_pkg::ASRP_RECOVER;
        end else if (take_write) begin
          next_r = start_write(next_r, req_addr, req_wdata);
        end else if (take_read) begin
          next_r = start_read(next_r, req_addr);
        end
      end

      // read open until the slower access time has passed
      asrp_pkg::ASRP_RD_WAIT: begin
        if (wait_done) begin
          next_r = finish_read(next_r, data_lines_in);
        end
      end

      // strobe rises first; data and address held a cycle more
      asrp_pkg::ASRP_WR_PULSE: begin
        if (wait_done) begin
          next_r.write_n = 1'b1;
          next_r.state   = asrp_pkg::ASRP_WR_END;
        end
      end

      // selects and data drivers let go together
      asrp_pkg::ASRP_WR_END: begin
        next_r = finish_write(next_r);
      end

      // bus turnaround before the next cycle may drive
      asrp_pkg::ASRP_GAP: begin
        if (wait_done) begin
          next_r.state = asrp_pkg::ASRP_IDLE;
        end
      end

      // unknown code: park the pins and start over from idle
      default: begin
        next_r       = parked(next_r);
        next_r.state = asrp_pkg::ASRP_IDLE;
      end
    endcase
  end

  // single register stage for all state
  always_ff @(posedge clk) begin
    if (srst) begin
      r.state               <= asrp_pkg::ASRP_RECOVER;
      r.cnt                 <= cyc(REC_CYCLES);
      r.word_address        <= '0;
      r.wdata               <= '0;
      r.rdata               <= '0;
      r.rvalid              <= 1'b0;
      r.select_low_active_n <= 1'b1;
      r.select_high_active  <= 1'b0;
      r.write_n             <= 1'b1;
      r.oe_n                <= 1'b1;
      r.data_oe             <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

endmodule

// file: dv/asrp_checker.sv
// assertions on the host port pins
`timescale 1ns/1ps
module asrp_checker #(parameter int REC_CYCLES = 4) (
  input wire logic clk, srst, standby_req, select_low_active_n, write_n,
  input wire logic [16:0] word_address);
  logic [3:0] up; // edges since reset or parked standby, saturating
  always_ff @(posedge clk)
    up <= (srst || (standby_req && select_low_active_n)) ? 4'h0
          : up + 4'(up != 4'hf);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_ah; !write_n && !$past(write_n) |-> $stable(word_address);
  endproperty
  a_ah: assert property (p_ah) else $error("address moved");
  property p_su; $rose(write_n) |-> !$past(write_n, 3);
  endproperty
  a_su: assert property (p_su) else $error("strobe short");
  property p_rc; !select_low_active_n |-> up >= REC_CYCLES;
  endproperty
  a_rc: assert property (p_rc) else $error("select early");
  property p_sb; standby_req && $past(standby_req) && select_low_active_n
    |=> select_low_active_n; endproperty
  a_sb: assert property (p_sb) else $error("select in standby");
endmodule

// file: dv/asrp_sram_model.sv
// static memory model behind the host port
`timescale 1ns/1ps
module asrp_sram_model (input wire logic [16:0] word_address,
  input wire logic select_low_active_n, select_high_active, write_n, oe_n,
  input wire logic [7:0] din, output logic [7:0] dout);
  logic [7:0] mem [0:131071];
  logic wact = 1'b0, ok = 1'b0;
  wire sel = !select_low_active_n && select_high_active;
  wire drv = sel && write_n && !oe_n;
  // write held open, stored on its first trailing edge
  always @* begin
    if (sel && !write_n) wact = 1'b1;
    else if (wact) {wact, mem[word_address]} = {1'b0, din};
  end
  // slow access time; outputs drop at once
  always @(drv) begin
    ok = 1'b0;
    if (drv) ok <= #(asrp_pkg::T_ACC_SEL_NS) 1'b1;
  end
  assign dout = ok ? mem[word_address] : ~mem[word_address];
endmodule

// file: dv/test_async_sram_128k_x8_port.sv
// bench for the host port
`timescale 1ns/1ps
module test_async_sram_128k_x8_port;
  logic clk = 1'b0;
  logic srst, req_valid, req_write, standby_req, req_ready, rsp_valid;
  logic select_low_active_n, select_high_active, write_n, oe_n, data_lines_oe;
  logic [16:0] req_addr, word_address, a;
  logic [7:0] req_wdata, rsp_rdata, data_lines_out, data_lines_in, mem_q, d;
  logic [7:0] ref_mem [logic [16:0]], exp_q [$];
  localparam int REC = 4; // short recovery keeps the run brief
  int error_cnt = 0, n_compared = 0;
  int k = 0;
  assign data_lines_in = data_lines_oe ? data_lines_out : mem_q;
  asrp_host #(.REC_CYCLES(REC)) DUT (.*);
  asrp_sram_model u_mem (.*, .din(data_lines_in), .dout(mem_q));
  initial forever #12.5 clk = ~clk;
  task automatic chk(input string what, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) error_cnt++;
    if (g !== e) $display("[FAIL] %s exp %h got %h", what, e, g);
  endtask
  task automatic tally_and_finish;
    $display("%0d checks, %0d errors", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // held until taken; reads queue the byte
  task automatic xfer(input logic w);
    @(negedge clk);
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    if (w) ref_mem[a] = d;
    else exp_q.push_back(ref_mem[a]);
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  // answer stands one cycle
  always @(negedge clk)
    if (rsp_valid === 1'b1) chk("rdata", exp_q.pop_front(), rsp_rdata);
  initial begin
    {srst, req_valid, req_write, standby_req} = 4'h8;
    {req_addr, req_wdata} = '0;
    void'($urandom(18));
    repeat (20) @(negedge clk);
    srst = 1'b0;
    // range ends, then random pairs
    for (int i = 0; i < 40; i++) begin
      a = i < 2 ? {17{i[0]}} : 17'($urandom);
      d = 8'($urandom);
      xfer(1'b1);
      xfer(1'b0);
    end
    // standby refuses; data kept
    standby_req = 1'b1;
    repeat (8) @(negedge clk);
    chk("standby", 8'h00, {7'h00, req_ready});
    standby_req = 1'b0;
    // recovery wait counts from the release of standby
    while (req_ready !== 1'b1) begin
      @(negedge clk);
      k++;
    end
    chk("recover", 8'(REC), 8'(k));
    xfer(1'b0);
    repeat (10) @(negedge clk);
    chk("pending", 8'h00, 8'(exp_q.size()));
    tally_and_finish();
  end
  // hang guard
  initial begin
    #125000 error_cnt++;
    tally_and_finish();
  end
endmodule
bind asrp_host asrp_checker #(.REC_CYCLES(REC_CYCLES)) u_chk (.*);
